// file: rtl/acc_store_shift_subtract_ops.sv
// Execution logic for store, barrel shift and subtract operations on the sum and index words.
`timescale 1ns/100ps
module acc_store_shift_subtract_ops (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Decoded command.
  input wire logic cmd_valid,
  input wire acc_ops_pkg::cmd_t cmd,
  output logic cmd_ready,
  // Core state loads.
  input wire logic load_sum,
  input wire logic [acc_ops_pkg::ACC_W-1:0] load_sum_value,
  input wire logic load_shadow,
  input wire logic [acc_ops_pkg::ACC_W-1:0] load_shadow_value,
  input wire logic load_count,
  input wire logic [acc_ops_pkg::CNT_W-1:0] load_count_value,
  input wire logic sign_extend_flag,
  input wire logic borrow_set,
  // Pre-update index values from the indirect addressing path.
  input wire logic [acc_ops_pkg::IDX_N*acc_ops_pkg::WORD_W-1:0] index_word_bank_in,
  // Results.
  output logic [acc_ops_pkg::ACC_W-1:0] sum_r,
  output logic [acc_ops_pkg::ACC_W-1:0] sum_shadow_register_r,
  output logic [acc_ops_pkg::CNT_W-1:0] shift_count_holder_r,
  output logic borrow_out_r,
  output logic index_wr_valid_r,
  output logic [acc_ops_pkg::SEL_W-1:0] index_wr_sel_r,
  output logic [acc_ops_pkg::WORD_W-1:0] index_wr_data_r,
  output acc_ops_pkg::mem_wr_t mem_wr_r,
  output logic busy
);

  // ==========================================================
  // Helpers.

  // Selects one word of the flattened index bank.
  function automatic logic [acc_ops_pkg::WORD_W-1:0] pick_index(
    input logic [acc_ops_pkg::IDX_N*acc_ops_pkg::WORD_W-1:0] bank,
    input logic [acc_ops_pkg::SEL_W-1:0] sel
  );
    pick_index = bank[sel*acc_ops_pkg::WORD_W +: acc_ops_pkg::WORD_W];
  endfunction

  // Sum minus shadow minus an extra bit; returns the borrow in the top bit.
  function automatic logic [acc_ops_pkg::ACC_W:0] sub_borrow(
    input logic [acc_ops_pkg::ACC_W-1:0] a,
    input logic [acc_ops_pkg::ACC_W-1:0] b,
    input logic extra
  );
    sub_borrow = {1'b0, a} - {1'b0, b} - {{acc_ops_pkg::ACC_W{1'b0}}, extra};
  endfunction

  // True for the two barrel shift forms, which leave the borrow flag alone.
  function automatic logic is_shift_op(
    input acc_ops_pkg::op_t op
  );
    is_shift_op = (op == acc_ops_pkg::OP_COARSE_SHIFT) || (op == acc_ops_pkg::OP_FINE_SHIFT);
  endfunction

  // True for the two buffer subtract forms, which update both the sum and the borrow flag.
  function automatic logic is_sub_op(
    input acc_ops_pkg::op_t op
  );
    is_sub_op = (op == acc_ops_pkg::OP_SUBTRACT_BUFFER)
      || (op == acc_ops_pkg::OP_SUBTRACT_BUFFER_WITH_BORROW);
  endfunction

  // ==========================================================
  // Shifter.
  logic [4:0] shift_amt;
  logic [acc_ops_pkg::ACC_W-1:0] shifted;
  logic [acc_ops_pkg::ACC_W:0] diff;
  logic take;

  assign take = cmd_valid && cmd_ready;
  assign diff = sub_borrow(sum_r, sum_shadow_register_r,
    (cmd.op == acc_ops_pkg::OP_SUBTRACT_BUFFER_WITH_BORROW) ? ~borrow_out_r : 1'b0);

  // Amount comes from count bit 4 for the coarse form, the low nibble for the fine form.
  always_comb begin
    shift_amt = 5'h00;
    if (cmd.op == acc_ops_pkg::OP_COARSE_SHIFT) begin
      shift_amt = shift_count_holder_r[acc_ops_pkg::COARSE_BIT] ? acc_ops_pkg::COARSE_AMT : 5'h00;
    end
    if (cmd.op == acc_ops_pkg::OP_FINE_SHIFT) begin
      shift_amt = {1'b0, shift_count_holder_r[acc_ops_pkg::FINE_LSB +: acc_ops_pkg::FINE_W]};
    end
  end

  right_shifter u_shift (
    .din(sum_r),
    .amount(shift_amt),
    .sign_fill(sign_extend_flag),
    .dout(shifted)
  );

  // ==========================================================
  // Multi-cycle stall for store-index costs.
  logic [7:0] stall_r;
  logic [7:0] cost;

  // Extra cycles beyond the first for one store.
  always_comb begin
    cost = 8'h00;
    if (cmd.op == acc_ops_pkg::OP_STORE_INDEX_WORD) begin
      if (cmd.operand_ext) begin
        cost = acc_ops_pkg::EXT_CYC - acc_ops_pkg::BASE_CYC + {4'h0, cmd.wait_states};
        if (cmd.code_ext) begin
          cost = cost + acc_ops_pkg::EXT_CODE_CYC;
        end
      end else if (cmd.same_single_access_ram) begin
        cost = acc_ops_pkg::CONFLICT_CYC;
      end
    end
  end

  assign cmd_ready = (stall_r == 8'h00);
  assign busy = !cmd_ready;

  // Counts down the extra cycles of the store just taken.
  // Fixed extras are charged on every external or RAM-conflict store-index command, so a repeat controller
  // upstream must discount them to reach the run totals.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stall_r <= 8'h00;
    end else if (take) begin
      stall_r <= cost;
    end else if (stall_r != 8'h00) begin
      stall_r <= stall_r - 8'h01;
    end
  end

  // ==========================================================
  // Sum register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sum_r <= acc_ops_pkg::ACC_RST;
    end else if (take && is_shift_op(cmd.op)) begin
      sum_r <= shifted;
    end else if (take && is_sub_op(cmd.op)) begin
      sum_r <= diff[acc_ops_pkg::ACC_W-1:0];
    end else if (load_sum) begin
      sum_r <= load_sum_value;
    end
  end

  // Shadow and count registers are loaded only by the core, never by these ops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sum_shadow_register_r <= acc_ops_pkg::ACC_RST;
      shift_count_holder_r <= acc_ops_pkg::WORD_RST;
    end else begin
      if (load_shadow) begin
        sum_shadow_register_r <= load_shadow_value;
      end
      if (load_count) begin
        shift_count_holder_r <= load_count_value;
      end
    end
  end

  // ==========================================================
  // Borrow flag; a borrow clears it, otherwise it is set.
  // A subtract outranks the core's set pulse, so the arithmetic result is never lost.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      borrow_out_r <= 1'b0;
    end else if (take && is_sub_op(cmd.op)) begin
      borrow_out_r <= ~diff[acc_ops_pkg::ACC_W];
    end else if (borrow_set) begin
      borrow_out_r <= 1'b1;
    end
  end

  // ==========================================================
  // Index write-back.
  // Select and data register every cycle; only the valid pulse qualifies them.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      index_wr_valid_r <= 1'b0;
      index_wr_sel_r <= '0;
      index_wr_data_r <= acc_ops_pkg::WORD_RST;
    end else begin
      index_wr_valid_r <= take && (cmd.op == acc_ops_pkg::OP_INDEX_WORD_MINUS_SHORT_CONST);
      index_wr_sel_r <= cmd.index_sel;
      index_wr_data_r <= pick_index(index_word_bank_in, cmd.index_sel)
        - {8'h00, cmd.imm};
    end
  end

  // ==========================================================
  // Memory writes for the two store operations.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr_r <= '0;
    end else begin
      mem_wr_r.valid <= 1'b0;
      if (take && cmd.op == acc_ops_pkg::OP_STORE_LOW_TO_MAPPED_REG) begin
        mem_wr_r.valid <= 1'b1;
        mem_wr_r.addr <= {acc_ops_pkg::MMR_PAGE, cmd.offset};
        mem_wr_r.data <= sum_r[acc_ops_pkg::WORD_W-1:0];
      end else if (take && cmd.op == acc_ops_pkg::OP_STORE_INDEX_WORD) begin
        mem_wr_r.valid <= 1'b1;
        mem_wr_r.addr <= cmd.data_addr;
        mem_wr_r.data <= pick_index(index_word_bank_in, cmd.index_sel);
      end
    end
  end

endmodule

// file: rtl/acc_ops_pkg.sv
// Constants, operation codes and carrier types for the accumulator store, shift and subtract group.
package acc_ops_pkg;

  // ==========================================================
  // Widths and fixed values.
  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int IDX_N = 8;
  localparam int SEL_W = 3;
  localparam int OFS_W = 7;
  localparam int ADDR_W = 16;
  localparam int IMM_W = 8;
  localparam int CNT_W = 16;
  localparam int COARSE_BIT = 4;
  localparam int FINE_LSB = 0;
  localparam int FINE_W = 4;
  localparam logic [4:0] COARSE_AMT = 5'h10;
  localparam logic [8:0] MMR_PAGE = 9'h000;
  localparam logic [3:0] WAIT_W = 4'h0;
  localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  // Cycle figures of the store-index timing.
  localparam logic [7:0] BASE_CYC = 8'h01;
  localparam logic [7:0] CONFLICT_CYC = 8'h01;
  localparam logic [7:0] EXT_CYC = 8'h02;
  localparam logic [7:0] EXT_CODE_CYC = 8'h02;

  // ==========================================================
  // Operation codes.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_STORE_LOW_TO_MAPPED_REG,
    OP_STORE_INDEX_WORD,
    OP_COARSE_SHIFT,
    OP_FINE_SHIFT,
    OP_SUBTRACT_BUFFER,
    OP_SUBTRACT_BUFFER_WITH_BORROW,
    OP_INDEX_WORD_MINUS_SHORT_CONST
  } op_t;

  // ==========================================================
  // Carrier types.
  typedef struct packed {
    op_t op;
    logic [OFS_W-1:0] offset;
    logic [SEL_W-1:0] index_sel;
    logic [IMM_W-1:0] imm;
    logic [ADDR_W-1:0] data_addr;
    logic same_single_access_ram;
    logic operand_ext;
    logic code_ext;
    logic [3:0] wait_states;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } mem_wr_t;

endpackage

// file: rtl/right_shifter.sv
// Barrel right shifter with zero or sign fill.
`timescale 1ns/100ps
module right_shifter (
  // Operand and amount.
  input wire logic [acc_ops_pkg::ACC_W-1:0] din,
  input wire logic [4:0] amount,
  input wire logic sign_fill,
  // Result.
  output logic [acc_ops_pkg::ACC_W-1:0] dout
);

  // Arithmetic shift for sign fill, logical shift for zero fill, in two separate branches.
  always_comb begin
    if (sign_fill) begin
      dout = $signed(din) >>> amount;
    end else begin
      dout = din >> amount;
    end
  end

endmodule

// file: test/acc_ops_properties.sv
// Concurrent checks on the store, shift and subtract block.
`timescale 1ns/100ps
module acc_ops_properties (
  // Watched ports.
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire acc_ops_pkg::cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic [31:0] sum_r,
  input wire logic [31:0] sum_shadow_register_r,
  input wire logic [15:0] shift_count_holder_r,
  input wire logic borrow_out_r,
  input wire logic index_wr_valid_r,
  input wire logic [2:0] index_wr_sel_r,
  input wire logic [15:0] index_wr_data_r,
  input wire logic [127:0] index_word_bank_in,
  input wire acc_ops_pkg::mem_wr_t mem_wr_r,
  input wire logic busy
);
  // ======================================================
  // Helpers: one take strobe for each operation.
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic tk = cmd_valid && cmd_ready;
  wire logic t_low = tk && cmd.op == acc_ops_pkg::OP_STORE_LOW_TO_MAPPED_REG;
  wire logic t_six = tk && cmd.op == acc_ops_pkg::OP_STORE_INDEX_WORD;
  wire logic t_crs = tk && cmd.op == acc_ops_pkg::OP_COARSE_SHIFT;
  wire logic t_fin = tk && cmd.op == acc_ops_pkg::OP_FINE_SHIFT;
  wire logic t_sub = tk && cmd.op == acc_ops_pkg::OP_SUBTRACT_BUFFER;
  wire logic t_sbw = tk && cmd.op == acc_ops_pkg::OP_SUBTRACT_BUFFER_WITH_BORROW;
  wire logic t_isub = tk && cmd.op == acc_ops_pkg::OP_INDEX_WORD_MINUS_SHORT_CONST;
  wire logic [15:0] wd = index_word_bank_in[cmd.index_sel*16 +: 16];
  wire logic [32:0] df = {1'b0, sum_r} - {1'b0, sum_shadow_register_r};
  wire logic [32:0] dfb = df - 33'(!borrow_out_r);
  // ======================================================
  // Assertions.
  sub_result_a: assert property (t_sub |=> sum_r == $past(df[31:0]) &&
    borrow_out_r == !$past(df[32])) else $error("subtract result wrong");
  subb_result_a: assert property (t_sbw |=> sum_r == $past(dfb[31:0]) &&
    borrow_out_r == !$past(dfb[32])) else $error("borrow subtract wrong");
  shadow_keep_a: assert property (t_sub || t_sbw |=>
    $stable(sum_shadow_register_r)) else $error("shadow changed");
  coarse_hold_a: assert property (t_crs && !shift_count_holder_r[4] |=>
    $stable(sum_r)) else $error("coarse shift moved sum");
  shift_borrow_a: assert property (t_crs || t_fin |=> $stable(borrow_out_r))
    else $error("shift altered borrow");
  low_store_a: assert property (t_low |=> mem_wr_r.valid &&
    mem_wr_r.addr == {9'h000, $past(cmd.offset)} && mem_wr_r.data == $past(sum_r[15:0]))
    else $error("low store wrong");
  index_store_a: assert property (t_six |=> mem_wr_r.valid &&
    mem_wr_r.data == $past(wd) && mem_wr_r.addr == $past(cmd.data_addr))
    else $error("index store wrong");
  conflict_cycle_a: assert property (t_six && cmd.same_single_access_ram && !cmd.operand_ext |=>
    busy ##1 cmd_ready) else $error("conflict cycle wrong");
  ext_wait_a: assert property (t_six && cmd.operand_ext && !cmd.code_ext &&
    cmd.wait_states == 4'h1 |=> busy [*2] ##1 cmd_ready) else $error("external store cost wrong");
  index_sub_a: assert property (t_isub |=> index_wr_valid_r &&
    index_wr_data_r == 16'($past(wd) - $past(cmd.imm))) else $error("index subtract wrong");
  index_sel_a: assert property (t_isub |=> index_wr_sel_r == $past(cmd.index_sel))
    else $error("index write select wrong");
  one_cycle_a: assert property (t_sub || t_sbw || t_crs || t_fin |=> cmd_ready)
    else $error("single cycle op stalled");
  c_ext: cover property (t_six && cmd.operand_ext);
  c_sbw: cover property (t_sbw);
  c_crs: cover property (t_crs && shift_count_holder_r[4]);
endmodule
bind acc_store_shift_subtract_ops acc_ops_properties acc_ops_properties_inst (.clock, .rst_n,
  .cmd_valid, .cmd, .cmd_ready, .sum_r, .sum_shadow_register_r, .shift_count_holder_r,
  .borrow_out_r, .index_wr_valid_r, .index_wr_sel_r, .index_wr_data_r, .index_word_bank_in,
  .mem_wr_r, .busy);

// file: test/tb_acc_store_shift_subtract_ops.sv
// Self-checking bench for the store, shift and subtract block.
`timescale 1ns/100ps
module tb_acc_store_shift_subtract_ops;
  logic clock = 0, rst_n = 0, cmd_valid = 0, load_sum = 0, load_shadow = 0, load_count = 0;
  logic sign_extend_flag = 0, borrow_set = 0, pend = 0, b = 0;
  acc_ops_pkg::cmd_t cmd = '0;
  logic [31:0] load_sum_value = 0, load_shadow_value = 0, s = 0, h = 0;
  logic [15:0] load_count_value = 0, c = 0, index_wr_data_r, shift_count_holder_r;
  logic [127:0] index_word_bank_in = 0;
  wire logic cmd_ready, borrow_out_r, index_wr_valid_r, busy;
  wire logic [31:0] sum_r, sum_shadow_register_r;
  wire logic [2:0] index_wr_sel_r;
  wire acc_ops_pkg::mem_wr_t mem_wr_r;
  logic [101:0] q[$], e, o;
  int errors = 0, compares = 0, cyc = 0;
  acc_store_shift_subtract_ops acc_store_shift_subtract_ops_inst (.clock, .rst_n, .cmd_valid,
    .cmd, .cmd_ready, .load_sum, .load_sum_value, .load_shadow, .load_shadow_value,
    .load_count, .load_count_value, .sign_extend_flag, .borrow_set, .index_word_bank_in,
    .sum_r, .sum_shadow_register_r, .shift_count_holder_r, .borrow_out_r, .index_wr_valid_r,
    .index_wr_sel_r, .index_wr_data_r, .mem_wr_r, .busy);
  initial forever #5 clock = ~clock;
  // ======================================================
  // Monitor: a take seen before an edge shows its result right after it.
  always @(negedge clock) pend <= cmd_valid && cmd_ready;
  always @(posedge clock) begin
    #2;
    o = {sum_shadow_register_r, shift_count_holder_r, index_wr_sel_r, borrow_out_r, sum_r,
      mem_wr_r.valid, index_wr_valid_r, mem_wr_r.valid ?
      mem_wr_r.data : (index_wr_valid_r ? index_wr_data_r : 16'h0000)};
    if (pend) begin
      e = q.size() ? q.pop_front() : ~o;
      compares++;
      if (o !== e) begin
        errors++;
        $display("Error at %0t: got %h expected %h", $time, o, e);
      end
    end
  end
  // A hang is cut short well past the expected run length.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [31:0] sh(logic [31:0] v, logic [4:0] n);
    // Separate returns keep the arithmetic shift signed; a mixed ternary would not.
    if (sign_extend_flag) return $signed(v) >>> n;
    return v >> n;
  endfunction
  // A refused command is withdrawn, never left standing.
  task automatic wait_ready();
    while (!cmd_ready) begin
      cmd_valid = 0;
      @(posedge clock);
      #1;
    end
  endtask
  task automatic ld();
    wait_ready();
    cmd_valid = 0;
    {load_sum, load_shadow, load_count} = 3'h7;
    {borrow_set, sign_extend_flag} = 2'($urandom);
    load_sum_value = $urandom;
    load_shadow_value = $urandom;
    load_count_value = $urandom;
    for (int k = 0; k < 4; k++) index_word_bank_in[32*k +: 32] = $urandom;
    {s, h, c} = {load_sum_value, load_shadow_value, load_count_value};
    b = b | borrow_set;
    @(posedge clock);
    #1;
    {load_sum, load_shadow, load_count, borrow_set} = 4'h0;
  endtask
  task automatic issue(acc_ops_pkg::op_t op);
    acc_ops_pkg::cmd_t k;
    logic [15:0] w;
    logic [32:0] d;
    logic [17:0] f;
    logic [63:0] r;
    wait_ready();
    r = {$urandom, $urandom};
    k = r[$bits(k)-1:0];
    k.op = op;
    k.wait_states &= 4'h3;
    if (k.operand_ext) k.same_single_access_ram = 0;
    w = index_word_bank_in[k.index_sel*16 +: 16];
    f = 18'h00000;
    d = {1'b0, s} - {1'b0, h} - 33'(op == acc_ops_pkg::OP_SUBTRACT_BUFFER_WITH_BORROW && !b);
    case (op)
      acc_ops_pkg::OP_STORE_LOW_TO_MAPPED_REG: f = {2'b10, s[15:0]};
      acc_ops_pkg::OP_STORE_INDEX_WORD: f = {2'b10, w};
      acc_ops_pkg::OP_COARSE_SHIFT: s = sh(s, c[4] ? 5'h10 : 5'h00);
      acc_ops_pkg::OP_FINE_SHIFT: s = sh(s, {1'b0, c[3:0]});
      acc_ops_pkg::OP_INDEX_WORD_MINUS_SHORT_CONST: f = {2'b01, 16'(w - k.imm)};
      default: {b, s} = {!d[32], d[31:0]};
    endcase
    cmd = k;
    cmd_valid = 1;
    q.push_back({h, c, k.index_sel, b, s, f});
    @(posedge clock);
    #1;
  endtask
  // ======================================================
  // Main sequence: coarse then fine shift, then two random ops back to back.
  initial begin
    void'($urandom(40));
    repeat (16) @(posedge clock);
    #1;
    rst_n = 1;
    repeat (60) begin
      ld();
      issue(acc_ops_pkg::OP_COARSE_SHIFT);
      issue(acc_ops_pkg::OP_FINE_SHIFT);
      issue(acc_ops_pkg::op_t'(1 + $urandom % 7));
      issue(acc_ops_pkg::op_t'(1 + $urandom % 7));
    end
    wait_ready();
    cmd_valid = 0;
    repeat (3) @(posedge clock);
    // Every noted result must have been seen by the monitor.
    if (q.size() != 0) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, q.size(), 0);
    end
    end_sim();
  end
endmodule
